// >>> rtl/stall_prev_pkg.sv
/*
 * Shared types and constants for the stall prevention supervisor.
 * Assumes a 100 MHz control clock; all levels are integer units.
 */
package stall_prev_pkg;

    localparam int CLOCK_HZ = 100_000_000;
    localparam int TICK_US = 1000; // control tick period in us
    localparam int TICK_CYCLES = (CLOCK_HZ / 1_000_000) * TICK_US;
    localparam int RUN_RECOVER_MS = 100;
    localparam logic [15:0] RUN_RECOVER_TICKS =
        16'((RUN_RECOVER_MS * 1000) / TICK_US);

    localparam logic [7:0] PCT_ACCEL_REDUCE = 8'h55; // 85 percent
    localparam logic [7:0] PCT_LEVEL_MAX = 8'h96; // 150 percent
    localparam logic [7:0] PCT_RUN_MIN = 8'h1E; // 30 percent
    localparam logic [7:0] PCT_RUN_HYST = 8'h02; // 2 percent
    localparam logic [7:0] PCT_RUN_FLOOR = 8'h28; // 40 percent
    localparam logic [15:0] FREQ_RUN_MIN = 16'h003C; // 6.0 Hz, 0.1 Hz unit
    localparam logic [15:0] BUS_STALL_200 = 16'h0179; // 377 Vdc
    localparam logic [15:0] BUS_STALL_400 = 16'h02F2; // 754 Vdc
    localparam logic [15:0] RECOVERY_TIME_MAX = 16'hEA60; // 6000.0 s
    localparam logic [3:0] DECEL_MIN_DIV = 4'hA; // rate cap 10x

    typedef enum logic [1:0] {
        RAMP_NORMAL,
        RAMP_HOLD,
        RAMP_DECEL,
        RAMP_FAST
    } ramp_cmd_t;

    typedef enum logic [1:0] {
        DECEL_SEL_PER_TIME,
        DECEL_SEL_ONE,
        DECEL_SEL_TWO,
        DECEL_SEL_RECOVERY
    } decel_sel_t;

    typedef enum {
        ST_IDLE,
        ST_ACC_SLOW,
        ST_ACC_HOLD,
        ST_PM_HOLD,
        ST_PM_DECEL,
        ST_PM_WAIT,
        ST_RUN_DECEL,
        ST_RUN_WAIT
    } stall_state_t;

    typedef struct packed {
        logic [1:0] accel_stall_select;
        logic [7:0] accel_stall_level; // percent of rated current
        logic [7:0] accel_stall_floor; // percent of rated current
        logic [15:0] stall_recovery_decel_time; // 0.1 s unit
        logic [15:0] stall_detect_ticks;
        logic [2:0] decel_stall_select;
        logic [15:0] target_bus_level; // Vdc
        logic [1:0] run_stall_select;
        logic [7:0] run_stall_level; // percent
        logic run_level_auto_reduce;
        logic input_voltage_setting; // 0: 200 V class, 1: 400 V class
        logic [7:0] carrier_level_max; // percent, from derating select
        logic pm_open_loop_mode;
    } stall_cfg_t;

    typedef struct packed {
        logic accelerating;
        logic decelerating;
        logic at_speed;
        logic [15:0] out_freq; // 0.1 Hz unit
        logic [15:0] base_freq; // 0.1 Hz unit
        logic [7:0] out_current; // percent of rated current
        logic [15:0] bus_voltage; // Vdc
        logic [7:0] analog_gain; // percent scale of run level
    } stall_meas_t;

    typedef struct packed {
        ramp_cmd_t ramp_cmd;
        decel_sel_t decel_sel;
        logic [3:0] decel_rate_mult; // 1 = programmed rate
        logic bus_hold_trim; // 1: slow the decel, 0: speed up
        logic cfg_reject;
    } stall_out_t;

endpackage

// >>> rtl/stall_prevention_ctrl.sv
/*
 * Stall prevention supervisor: watches output current and bus voltage
 * and steers the frequency ramp generator through a ramp command.
 * Assumes measurements are synchronous to clock and already scaled.
 */
//
// Contract
// - accel select 0: no accel intervention, programmed accel time
// - V/f select 1: slow accel when current above 85% level for dwell
// - V/f: hold accel above level; resume after dwell below level
// - accel level reduced above base speed, not below floor
// - PM: hold, after dwell decel, stop under 85%, reaccel after dwell
// - recovery time zero: use selected decel time on stall
// - recovery time used only in PM mode with accel select 1
// - accel select 2: fastest accel keeping current under level
// - accel select 2 refused in PM mode
// - accel level in percent, capped 150% and carrier derating
// - decel select 0: plain decel, no bus action
// - decel select 1: pause decel while bus above stall level
// - bus stall level 377 V or 754 V by input voltage class
// - decel select 2: hold bus at target, time not under 1/10
// - decel select 4 and 5 refused in PM mode
// - decel select 5: trim decel to hold bus at target
// - run stall off at or below 6 Hz
// - run select 0: hold reference, no overcurrent action
// - run select 1: decel with time one when current over run level
// - reaccelerate after current under level minus 2% for 100 ms
// - run select 2: as 1 but decel time two
// - run level 30 to 150 percent, auto reduced above base speed
// - run level scaled by analog input
// - reduced run level not under 40% of programmed level
`timescale 1ns/10ps

module stall_prevention_ctrl #(
    parameter int TICK_DIV = stall_prev_pkg::TICK_CYCLES
) (
    input wire logic clock, // 100 MHz
    input wire logic reset_n, // async, active low
    input wire stall_prev_pkg::stall_cfg_t cfg, // settings
    input wire stall_prev_pkg::stall_meas_t meas, // ramp and sensors
    output stall_prev_pkg::stall_out_t ctrl, // ramp steering
    output logic stall_active // ramp command not normal, or bus hold trim on
);

    typedef struct packed {
        logic [31:0] div;
        logic tick;
        stall_prev_pkg::stall_state_t st;
        logic [15:0] dwell;
        stall_prev_pkg::stall_out_t out;
        logic active;
    } state_t;

    state_t s_q, s_d;

    // clamp to a ceiling
    function automatic logic [7:0] clamp8(input logic [7:0] v,
                                          input logic [7:0] hi);
        clamp8 = (v > hi) ? hi : v;
    endfunction

    // level * base / freq above base speed, never under floor
    function automatic logic [7:0] fade_level(input logic [7:0] lvl,
                                              input logic [7:0] floor_v,
                                              input logic [15:0] f,
                                              input logic [15:0] fb);
        logic [23:0] prod;
        logic [23:0] red;
        prod = 24'(lvl) * 24'(fb);
        red = (f > fb && f != 16'h0000) ? prod / 24'(f) : 24'(lvl);
        if (red < 24'(floor_v))
            fade_level = floor_v;
        else
            fade_level = red[7:0];
    endfunction

    logic [7:0] acc_cap, acc_lvl, acc_85, run_base, run_lvl, run_hyst;
    logic [15:0] bus_stall;
    logic [15:0] run_scaled;
    logic acc_sel_ok, dec_sel_ok;

    always_comb begin
        acc_cap = clamp8(cfg.carrier_level_max,
                         stall_prev_pkg::PCT_LEVEL_MAX);
        acc_lvl = fade_level(clamp8(cfg.accel_stall_level, acc_cap),
                             cfg.accel_stall_floor, meas.out_freq,
                             meas.base_freq);
        acc_85 = 8'((16'(acc_lvl) * 16'(stall_prev_pkg::PCT_ACCEL_REDUCE))
                 / 16'h0064);
        run_base = clamp8(cfg.run_stall_level, acc_cap);
        if (run_base < stall_prev_pkg::PCT_RUN_MIN)
            run_base = stall_prev_pkg::PCT_RUN_MIN;
        run_scaled = (16'(run_base) * 16'(meas.analog_gain)) / 16'h0064;
        run_lvl = clamp8(run_scaled[7:0] | {8{|run_scaled[15:8]}},
                         acc_cap);
        if (cfg.run_level_auto_reduce)
            run_lvl = fade_level(run_lvl,
                8'((16'(run_lvl) * 16'(stall_prev_pkg::PCT_RUN_FLOOR))
                   / 16'h0064),
                meas.out_freq, meas.base_freq);
        run_hyst = (run_lvl > stall_prev_pkg::PCT_RUN_HYST) ?
                   run_lvl - stall_prev_pkg::PCT_RUN_HYST : 8'h00;
        bus_stall = cfg.input_voltage_setting ?
                    stall_prev_pkg::BUS_STALL_400 :
                    stall_prev_pkg::BUS_STALL_200;
        acc_sel_ok = !(cfg.pm_open_loop_mode
                       && cfg.accel_stall_select == 2'h2);
        dec_sel_ok = !(cfg.pm_open_loop_mode
                       && (cfg.decel_stall_select == 3'h4
                           || cfg.decel_stall_select == 3'h5));
    end

    logic acc_sel1, recov_ok, run_sel, run_ok;
    assign acc_sel1 = cfg.accel_stall_select == 2'h1;
    // recovery time only counts in PM with select 1, and only if nonzero
    assign recov_ok = cfg.pm_open_loop_mode && acc_sel1
        && cfg.stall_recovery_decel_time != 16'h0000;
    assign run_sel = cfg.run_stall_select == 2'h1
                     || cfg.run_stall_select == 2'h2;
    assign run_ok = run_sel && meas.at_speed
                    && meas.out_freq > stall_prev_pkg::FREQ_RUN_MIN;

    always_comb begin
        logic dwell_done;
        logic cond;
        s_d = s_q;
        dwell_done = s_q.dwell >= cfg.stall_detect_ticks;
        cond = 1'b0;
        if (s_q.div >= TICK_DIV - 1) begin
            s_d.div = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.div = s_q.div + 32'h1;
            s_d.tick = 1'b0;
        end
        s_d.out.ramp_cmd = stall_prev_pkg::RAMP_NORMAL;
        s_d.out.decel_sel = stall_prev_pkg::DECEL_SEL_PER_TIME;
        s_d.out.decel_rate_mult = 4'h1;
        s_d.out.bus_hold_trim = 1'b0;
        s_d.out.cfg_reject = !acc_sel_ok || !dec_sel_ok;
        unique case (s_q.st)
            stall_prev_pkg::ST_IDLE: begin
                if (meas.accelerating && acc_sel_ok && acc_sel1) begin
                    if (!cfg.pm_open_loop_mode) begin
                        cond = meas.out_current > acc_85;
                        if (meas.out_current > acc_lvl)
                            s_d.st = stall_prev_pkg::ST_ACC_HOLD;
                        else if (cond && dwell_done)
                            s_d.st = stall_prev_pkg::ST_ACC_SLOW;
                    end else if (meas.out_current >= acc_lvl) begin
                        s_d.st = stall_prev_pkg::ST_PM_HOLD;
                    end
                end else if (meas.accelerating && acc_sel_ok
                             && cfg.accel_stall_select == 2'h2) begin
                    // fastest ramp unless at the level
                    s_d.out.ramp_cmd = (meas.out_current >= acc_lvl) ?
                        stall_prev_pkg::RAMP_HOLD :
                        stall_prev_pkg::RAMP_FAST;
                end else if (meas.decelerating && dec_sel_ok) begin
                    unique case (cfg.decel_stall_select)
                        3'h1: if (meas.bus_voltage > bus_stall)
                            s_d.out.ramp_cmd =
                                stall_prev_pkg::RAMP_HOLD;
                        3'h2: begin
                            // speed up to 10x while under target
                            s_d.out.decel_rate_mult =
                                (meas.bus_voltage < cfg.target_bus_level) ?
                                stall_prev_pkg::DECEL_MIN_DIV : 4'h1;
                            if (meas.bus_voltage > cfg.target_bus_level)
                                s_d.out.ramp_cmd = stall_prev_pkg::RAMP_HOLD;
                        end
                        3'h5: s_d.out.bus_hold_trim =
                            meas.bus_voltage > cfg.target_bus_level;
                        default: ; // 0 and 4 leave the ramp alone
                    endcase
                end else if (run_ok
                             && meas.out_current > run_lvl) begin
                    s_d.st = stall_prev_pkg::ST_RUN_DECEL;
                end
                // select 0 falls through with RAMP_NORMAL
            end
            stall_prev_pkg::ST_ACC_SLOW: begin
                s_d.out.ramp_cmd = stall_prev_pkg::RAMP_DECEL;
                s_d.out.decel_rate_mult = 4'h0; // half rate marker
                if (meas.out_current > acc_lvl)
                    s_d.st = stall_prev_pkg::ST_ACC_HOLD;
                else if (!meas.accelerating
                         || meas.out_current <= acc_85)
                    s_d.st = stall_prev_pkg::ST_IDLE;
            end
            stall_prev_pkg::ST_ACC_HOLD: begin
                s_d.out.ramp_cmd = stall_prev_pkg::RAMP_HOLD;
                cond = meas.out_current < acc_lvl;
                if (!meas.accelerating || (cond && dwell_done))
                    s_d.st = stall_prev_pkg::ST_IDLE;
            end
            stall_prev_pkg::ST_PM_HOLD: begin
                s_d.out.ramp_cmd = stall_prev_pkg::RAMP_HOLD;
                cond = 1'b1;
                if (dwell_done)
                    s_d.st = stall_prev_pkg::ST_PM_DECEL;
            end
            stall_prev_pkg::ST_PM_DECEL: begin
                s_d.out.ramp_cmd = stall_prev_pkg::RAMP_DECEL;
                s_d.out.decel_sel = recov_ok ?
                    stall_prev_pkg::DECEL_SEL_RECOVERY :
                    stall_prev_pkg::DECEL_SEL_PER_TIME;
                if (meas.out_current < acc_85)
                    s_d.st = stall_prev_pkg::ST_PM_WAIT;
            end
            stall_prev_pkg::ST_PM_WAIT: begin
                s_d.out.ramp_cmd = stall_prev_pkg::RAMP_HOLD;
                cond = 1'b1;
                if (dwell_done)
                    s_d.st = stall_prev_pkg::ST_IDLE;
            end
            stall_prev_pkg::ST_RUN_DECEL: begin
                s_d.out.ramp_cmd = stall_prev_pkg::RAMP_DECEL;
                s_d.out.decel_sel =
                    (cfg.run_stall_select == 2'h2) ?
                    stall_prev_pkg::DECEL_SEL_TWO :
                    stall_prev_pkg::DECEL_SEL_ONE;
                cond = meas.out_current < run_hyst;
                if (!run_sel || meas.out_freq <=
                    stall_prev_pkg::FREQ_RUN_MIN)
                    s_d.st = stall_prev_pkg::ST_IDLE;
                else if (cond)
                    s_d.st = stall_prev_pkg::ST_RUN_WAIT;
            end
            stall_prev_pkg::ST_RUN_WAIT: begin
                s_d.out.ramp_cmd = stall_prev_pkg::RAMP_HOLD;
                cond = meas.out_current < run_hyst;
                if (!cond)
                    s_d.st = stall_prev_pkg::ST_RUN_DECEL;
                else if (s_q.dwell >= stall_prev_pkg::RUN_RECOVER_TICKS)
                    s_d.st = stall_prev_pkg::ST_IDLE;
            end
        endcase
        // dwell restarts on state change or false condition
        if (s_d.st != s_q.st || !cond)
            s_d.dwell = '0;
        else if (s_q.tick && s_q.dwell != 16'hFFFF)
            s_d.dwell = s_q.dwell + 16'h1;
        s_d.active = s_d.out.ramp_cmd != stall_prev_pkg::RAMP_NORMAL
                     || s_d.out.bus_hold_trim;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign ctrl = s_q.out;
    assign stall_active = s_q.active;

    a_run_low_freq: assert property (
        @(posedge clock) disable iff (!reset_n)
        (s_q.st == stall_prev_pkg::ST_IDLE && !run_ok)
        |=> s_q.st != stall_prev_pkg::ST_RUN_DECEL)
        else $error("run stall entered while not allowed");
    a_pm_no_fast: assert property (
        @(posedge clock) disable iff (!reset_n)
        (cfg.pm_open_loop_mode && cfg.accel_stall_select == 2'h2)
        |=> ctrl.ramp_cmd != stall_prev_pkg::RAMP_FAST)
        else $error("fast accel in pm mode");
    a_dec_pause: assert property (
        @(posedge clock) disable iff (!reset_n)
        (s_q.st == stall_prev_pkg::ST_IDLE && !meas.accelerating
         && meas.decelerating && cfg.decel_stall_select == 3'h1
         && !cfg.pm_open_loop_mode && meas.bus_voltage > bus_stall)
        |=> ctrl.ramp_cmd == stall_prev_pkg::RAMP_HOLD)
        else $error("decel not paused on high bus");
    a_run_decel_sel: assert property (
        @(posedge clock) disable iff (!reset_n)
        (s_q.st == stall_prev_pkg::ST_RUN_DECEL
         && cfg.run_stall_select == 2'h2 && $stable(cfg.run_stall_select))
        |-> ##1 ctrl.decel_sel == stall_prev_pkg::DECEL_SEL_TWO)
        else $error("run stall used wrong decel time");
    a_recov_gate: assert property (
        @(posedge clock) disable iff (!reset_n)
        ctrl.decel_sel == stall_prev_pkg::DECEL_SEL_RECOVERY
        |-> $past(recov_ok))
        else $error("recovery decel used outside pm select 1");
    a_run_recover: assert property (
        @(posedge clock) disable iff (!reset_n)
        (s_q.st == stall_prev_pkg::ST_RUN_WAIT
         && s_d.st == stall_prev_pkg::ST_IDLE)
        |-> s_q.dwell >= stall_prev_pkg::RUN_RECOVER_TICKS)
        else $error("run recovery too early");
    a_acc_hold: assert property (
        @(posedge clock) disable iff (!reset_n)
        s_q.st == stall_prev_pkg::ST_ACC_HOLD && s_d.st == s_q.st
        |=> ctrl.ramp_cmd == stall_prev_pkg::RAMP_HOLD)
        else $error("accel not held above level");
    a_dwell_reset: assert property (
        @(posedge clock) disable iff (!reset_n)
        $changed(s_q.st) |-> s_q.dwell == 16'h0000)
        else $error("dwell not restarted");
    a_accel_off: assert property (
        @(posedge clock) disable iff (!reset_n)
        (s_q.st == stall_prev_pkg::ST_IDLE && cfg.accel_stall_select == 2'h0
         && meas.accelerating && !meas.decelerating)
        |=> ctrl.ramp_cmd == stall_prev_pkg::RAMP_NORMAL
            && (s_q.st == stall_prev_pkg::ST_IDLE
                || s_q.st == stall_prev_pkg::ST_RUN_DECEL))
        else $error("accel intervention with select 0");
    a_plain_decel: assert property (
        @(posedge clock) disable iff (!reset_n)
        (s_q.st == stall_prev_pkg::ST_IDLE && !meas.accelerating
         && meas.decelerating && cfg.decel_stall_select == 3'h0)
        |=> ctrl.ramp_cmd == stall_prev_pkg::RAMP_NORMAL
            && !ctrl.bus_hold_trim)
        else $error("bus action with decel select 0");
    a_bus_target: assert property (
        @(posedge clock) disable iff (!reset_n)
        (s_q.st == stall_prev_pkg::ST_IDLE && !meas.accelerating
         && meas.decelerating && cfg.decel_stall_select == 3'h2
         && meas.bus_voltage > cfg.target_bus_level)
        |=> ctrl.ramp_cmd == stall_prev_pkg::RAMP_HOLD
            && ctrl.decel_rate_mult == 4'h1)
        else $error("decel not held above target bus");
    a_cfg_refuse: assert property (
        @(posedge clock) disable iff (!reset_n)
        (cfg.pm_open_loop_mode && (cfg.decel_stall_select == 3'h4
                                   || cfg.decel_stall_select == 3'h5))
        |=> ctrl.cfg_reject)
        else $error("decel select 4 or 5 taken in pm mode");
    a_run_off: assert property (
        @(posedge clock) disable iff (!reset_n)
        (s_q.st == stall_prev_pkg::ST_IDLE && cfg.run_stall_select == 2'h0)
        |=> s_q.st != stall_prev_pkg::ST_RUN_DECEL)
        else $error("run stall entered with select 0");

endmodule // stall_prevention_ctrl

// >>> sim/stall_prevention_ctrl_tb_top.sv
/*
 * Self-checking bench for the stall prevention supervisor.
 * Assumes the design holds its own assertions and takes a short tick.
 */
`timescale 1ns/10ps

module stall_prevention_ctrl_tb_top;
    localparam int TDIV = 10; // short tick: 100 ms becomes 1000 cycles
    logic clock;
    logic reset_n;
    stall_prev_pkg::stall_cfg_t cfg;
    stall_prev_pkg::stall_meas_t meas;
    stall_prev_pkg::stall_out_t ctrl;
    logic stall_active;
    int n_mismatch;
    int compares;
    stall_prev_pkg::decel_sel_t exp_sel;

    stall_prevention_ctrl #(.TICK_DIV(TDIV)) dut (
        .clock(clock),
        .reset_n(reset_n),
        .cfg(cfg),
        .meas(meas),
        .ctrl(ctrl),
        .stall_active(stall_active)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic close_out();
        $display("counts: %0d compares, %0d mismatches", compares,
                 n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    // bounded wait, then one compare of the ramp command
    task automatic wait_cmd(input stall_prev_pkg::ramp_cmd_t c,
                            input int max);
        int i;
        i = 0;
        while (ctrl.ramp_cmd !== c && i < max) begin
            @(negedge clock);
            i++;
        end
        chk(ctrl.ramp_cmd === c, "ramp command not reached in time");
    endtask

    task automatic hold_cmd(input stall_prev_pkg::ramp_cmd_t c,
                            input int n);
        cyc(n);
        chk(ctrl.ramp_cmd === c, "ramp command differs");
    endtask

    // every test starts from reset so state never leaks across tests
    task automatic do_reset();
        reset_n = 1'b0;
        cfg = '0;
        cfg.accel_stall_level = 8'h64;
        cfg.accel_stall_floor = 8'h32;
        cfg.stall_detect_ticks = 16'h0003;
        cfg.target_bus_level = 16'h0172;
        cfg.run_stall_level = 8'h64;
        cfg.carrier_level_max = 8'h96;
        meas = '0;
        meas.out_freq = 16'h0258;
        meas.base_freq = 16'h0258;
        meas.bus_voltage = 16'h012C;
        meas.analog_gain = 8'h64;
        cyc(20);
        chk(ctrl === '0 && stall_active === 1'b0, "outputs not clear");
        reset_n = 1'b1;
        cyc(2);
    endtask

    task automatic tend(input string name);
        $display("test %s done", name);
    endtask

    initial begin
        n_mismatch = 0;
        compares = 0;
        do_reset();
        meas.accelerating = 1'b1;
        meas.out_current = 8'h78;
        hold_cmd(stall_prev_pkg::RAMP_NORMAL, 6);
        cfg.accel_stall_select = 2'h1;
        wait_cmd(stall_prev_pkg::RAMP_HOLD, 4);
        chk(stall_active === 1'b1, "hold not flagged");
        chk(ctrl.decel_sel === stall_prev_pkg::DECEL_SEL_PER_TIME,
            "recovery time used outside pm mode");
        meas.out_current = 8'h32;
        hold_cmd(stall_prev_pkg::RAMP_HOLD, 15);
        meas.out_current = 8'h6E;
        cyc(2);
        meas.out_current = 8'h32;
        hold_cmd(stall_prev_pkg::RAMP_HOLD, 18);
        wait_cmd(stall_prev_pkg::RAMP_NORMAL, 40);
        meas.out_current = 8'h5A;
        hold_cmd(stall_prev_pkg::RAMP_NORMAL, 3);
        wait_cmd(stall_prev_pkg::RAMP_DECEL, 50);
        chk(ctrl.decel_rate_mult === 4'h0, "accel not reduced");
        tend("accel_vf");

        do_reset();
        cfg.accel_stall_select = 2'h1;
        meas.accelerating = 1'b1;
        meas.base_freq = 16'h012C;
        meas.out_freq = 16'h00C8;
        meas.out_current = 8'h37;
        hold_cmd(stall_prev_pkg::RAMP_NORMAL, 6);
        meas.out_freq = 16'h0BB8;
        meas.out_current = 8'h28;
        hold_cmd(stall_prev_pkg::RAMP_NORMAL, 6);
        meas.out_current = 8'h37;
        wait_cmd(stall_prev_pkg::RAMP_HOLD, 6);
        do_reset();
        cfg.accel_stall_select = 2'h1;
        cfg.accel_stall_level = 8'hC8;
        cfg.carrier_level_max = 8'h78;
        meas.accelerating = 1'b1;
        meas.out_current = 8'h82;
        wait_cmd(stall_prev_pkg::RAMP_HOLD, 6);
        tend("accel_level");

        do_reset();
        cfg.accel_stall_select = 2'h2;
        meas.accelerating = 1'b1;
        meas.out_current = 8'h32;
        hold_cmd(stall_prev_pkg::RAMP_FAST, 4);
        chk(ctrl.cfg_reject === 1'b0, "select 2 refused in v/f");
        meas.out_current = 8'h78;
        cyc(4);
        chk(ctrl.ramp_cmd === stall_prev_pkg::RAMP_HOLD,
            "fast accel above level");
        cfg.pm_open_loop_mode = 1'b1;
        hold_cmd(stall_prev_pkg::RAMP_NORMAL, 4);
        chk(ctrl.cfg_reject === 1'b1, "select 2 taken in pm");
        for (int s = 4; s <= 5; s++) begin
            do_reset();
            cfg.pm_open_loop_mode = 1'b1;
            cfg.decel_stall_select = 3'(s);
            meas.decelerating = 1'b1;
            meas.bus_voltage = 16'h0190;
            hold_cmd(stall_prev_pkg::RAMP_NORMAL, 4);
            chk(ctrl.cfg_reject === 1'b1, "decel select taken");
        end
        tend("refusals");

        do_reset();
        meas.decelerating = 1'b1;
        meas.bus_voltage = 16'h0320;
        hold_cmd(stall_prev_pkg::RAMP_NORMAL, 4);
        chk(stall_active === 1'b0, "bus action with select 0");
        cfg.decel_stall_select = 3'h1;
        meas.bus_voltage = 16'h017A;
        hold_cmd(stall_prev_pkg::RAMP_HOLD, 4);
        meas.bus_voltage = 16'h0178;
        hold_cmd(stall_prev_pkg::RAMP_NORMAL, 4);
        cfg.input_voltage_setting = 1'b1;
        meas.bus_voltage = 16'h01F4;
        hold_cmd(stall_prev_pkg::RAMP_NORMAL, 4);
        meas.bus_voltage = 16'h02F3;
        hold_cmd(stall_prev_pkg::RAMP_HOLD, 4);
        meas.bus_voltage = 16'h02F1;
        hold_cmd(stall_prev_pkg::RAMP_NORMAL, 4);
        cfg.decel_stall_select = 3'h2;
        meas.bus_voltage = 16'h012C;
        cyc(4);
        chk(ctrl.decel_rate_mult === 4'hA, "decel not at 1/10");
        meas.bus_voltage = 16'h0190;
        hold_cmd(stall_prev_pkg::RAMP_HOLD, 4);
        chk(ctrl.decel_rate_mult === 4'h1, "decel sped up above target");
        cfg.decel_stall_select = 3'h5;
        cyc(4);
        chk(ctrl.bus_hold_trim === 1'b1 && stall_active === 1'b1,
            "no trim above target");
        meas.bus_voltage = 16'h012C;
        cyc(4);
        chk(ctrl.bus_hold_trim === 1'b0, "trim below target");
        tend("decel");

        do_reset();
        meas.at_speed = 1'b1;
        meas.out_current = 8'h78;
        hold_cmd(stall_prev_pkg::RAMP_NORMAL, 6);
        for (int s = 1; s <= 2; s++) begin
            do_reset();
            cfg.run_stall_select = 2'(s);
            meas.at_speed = 1'b1;
            meas.out_current = 8'h78;
            exp_sel = (s == 1) ? stall_prev_pkg::DECEL_SEL_ONE :
                stall_prev_pkg::DECEL_SEL_TWO;
            wait_cmd(stall_prev_pkg::RAMP_DECEL, 4);
            chk(ctrl.decel_sel === exp_sel, "wrong decel time");
            meas.out_current = 8'h63;
            hold_cmd(stall_prev_pkg::RAMP_DECEL, 10);
            meas.out_current = 8'h61;
            wait_cmd(stall_prev_pkg::RAMP_HOLD, 4);
            hold_cmd(stall_prev_pkg::RAMP_HOLD, 950);
            wait_cmd(stall_prev_pkg::RAMP_NORMAL, 100);
        end
        do_reset();
        cfg.run_stall_select = 2'h1;
        meas.at_speed = 1'b1;
        meas.out_current = 8'h78;
        meas.out_freq = 16'h003C;
        hold_cmd(stall_prev_pkg::RAMP_NORMAL, 6);
        meas.out_freq = 16'h003D;
        wait_cmd(stall_prev_pkg::RAMP_DECEL, 4);
        do_reset();
        cfg.run_stall_select = 2'h1;
        meas.at_speed = 1'b1;
        meas.out_current = 8'h3C;
        hold_cmd(stall_prev_pkg::RAMP_NORMAL, 6);
        meas.analog_gain = 8'h32;
        wait_cmd(stall_prev_pkg::RAMP_DECEL, 4);
        do_reset();
        cfg.run_stall_select = 2'h1;
        cfg.run_stall_level = 8'h14;
        meas.at_speed = 1'b1;
        meas.out_current = 8'h19;
        hold_cmd(stall_prev_pkg::RAMP_NORMAL, 6);
        meas.out_current = 8'h23;
        wait_cmd(stall_prev_pkg::RAMP_DECEL, 4);
        do_reset();
        cfg.run_stall_select = 2'h1;
        cfg.run_level_auto_reduce = 1'b1;
        meas.at_speed = 1'b1;
        meas.base_freq = 16'h012C;
        meas.out_freq = 16'h0BB8;
        meas.out_current = 8'h23;
        hold_cmd(stall_prev_pkg::RAMP_NORMAL, 6);
        cfg.run_level_auto_reduce = 1'b0;
        meas.out_current = 8'h2D;
        hold_cmd(stall_prev_pkg::RAMP_NORMAL, 6);
        cfg.run_level_auto_reduce = 1'b1;
        wait_cmd(stall_prev_pkg::RAMP_DECEL, 4);
        tend("run");

        for (int r = 0; r < 2; r++) begin
            do_reset();
            cfg.pm_open_loop_mode = 1'b1;
            cfg.accel_stall_select = 2'h1;
            cfg.stall_recovery_decel_time = (r == 0) ? 16'h0032 : 16'h0000;
            exp_sel = (r == 0) ? stall_prev_pkg::DECEL_SEL_RECOVERY :
                stall_prev_pkg::DECEL_SEL_PER_TIME;
            meas.accelerating = 1'b1;
            meas.out_current = 8'h64;
            wait_cmd(stall_prev_pkg::RAMP_HOLD, 4);
            wait_cmd(stall_prev_pkg::RAMP_DECEL, 40);
            chk(ctrl.decel_sel === exp_sel, "recovery decel");
            meas.out_current = 8'h5A;
            hold_cmd(stall_prev_pkg::RAMP_DECEL, 5);
            meas.out_current = 8'h54;
            wait_cmd(stall_prev_pkg::RAMP_HOLD, 4);
            wait_cmd(stall_prev_pkg::RAMP_NORMAL, 40);
        end
        tend("pm_accel");
        close_out();
    end

    // whole run is near 2700 cycles; over seven times that means a hang
    initial begin
        #200000;
        n_mismatch++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        close_out();
    end
endmodule // stall_prevention_ctrl_tb_top
